// File: two_wire_register_slave.sv
// Behaviour
// - Pins act as slave SCL/SDA after reset
// - Address is 1000 plus three port pins
// - Works at bus rates up to 400 kbps
// - Master uses seven-bit addressing only
// - Detect START and STOP while SCL high
// - MSB first, sampled on SCL high pulse
// - Receiver pulls SDA low to acknowledge
// - Bus reset sequence returns slave to idle
// - Master resynchronises with bus reset sequence
// - Address is channel, group, register number
// - Invalid register reads return zero
// - Four data bytes, most significant first
// - Acknowledge after every data byte except the last one read
// - Undefined register bits read as zero
// - Write: direction low, address, then data
// - Read: address write, repeated START, read
// - Master NACKs last byte, slave releases
// - Sequential reads and writes are supported
`timescale 1ns/1ps
`include "two_wire_regs.svh"
module two_wire_register_slave (
  input  wire logic        core_clk_in,
  input  wire logic        link_clk_in,
  input  wire logic        rst_n_in,
  i2c_link_if.device       link,
  input  wire logic        port_addr_4_in,
  input  wire logic        port_addr_3_in,
  input  wire logic        port_addr_2_in,
  input  wire logic [31:0] reg_rdata_in,
  input  wire logic        reg_hit_in,
  output logic             reg_rd_out,
  output logic             reg_wr_out,
  output logic      [23:0] reg_addr_out,
  output logic      [31:0] reg_wdata_out
);

  // ---------------- Link domain ----------------
  logic [4:0]                pin_s;
  logic                      scl_p_q;
  logic                      sda_p_q;
  two_wire_pkg::dev_state_t  state_q;
  logic [3:0]                bit_cnt_q;
  logic [7:0]                shift_q;
  logic                      rw_q;
  logic [1:0]                addr_cnt_q;
  logic [1:0]                byte_cnt_q;
  logic [23:0]               addr_q;
  logic [31:0]               wdata_q;
  logic                      req_tgl_q;
  logic                      req_we_q;
  logic [23:0]               req_addr_q;
  logic [31:0]               req_wdata_q;
  logic                      ack_s;
  logic                      ack_p_q;
  logic [31:0]               rword_q;
  logic                      ack_tgl_q;
  logic [31:0]               rdata_q;

  // Oversampling on the fast link clock resolves 400 kbps edges cleanly
  sync2 #(.WIDTH(5)) u_pin_sync (
    .clk_in   (link_clk_in),
    .rst_n_in (rst_n_in),
    .d_in     ({link.slave_scl_pin, link.slave_sda_pin,
                port_addr_4_in, port_addr_3_in, port_addr_2_in}),
    .q_out    (pin_s)
  );

  wire       scl_s      = pin_s[4];
  wire       sda_s      = pin_s[3];
  wire [6:0] own_addr   = {`SLV_ADDR_FIXED, pin_s[2:0]};
  wire       scl_rise   = scl_s & !scl_p_q;
  wire       scl_fall   = !scl_s & scl_p_q;
  wire       start_seen = scl_s & scl_p_q & sda_p_q & !sda_s;
  wire       stop_seen  = scl_s & scl_p_q & !sda_p_q & sda_s;
  wire       byte_done  = scl_fall & (bit_cnt_q == `ACK_SLOT);
  wire       addr_match = shift_q[7:1] == own_addr;
  wire       addr_done  = addr_cnt_q == `ADDR_BYTES;
  wire       word_last  = byte_cnt_q == `LAST_DATA_BYTE;
  wire       in_shift   = (state_q == two_wire_pkg::D_ADDR) | (state_q == two_wire_pkg::D_RX);
  wire       in_count   = in_shift | (state_q == two_wire_pkg::D_TX);
  wire       master_ack = scl_rise & (state_q == two_wire_pkg::D_ACK_RX) & !sda_s;

  // Fetch the first word on a read address, the next word when the master acks a last byte
  wire issue_rd = (byte_done & (state_q == two_wire_pkg::D_ADDR) & addr_match
                   & (shift_q[0] == `DIR_READ))
                | (master_ack & word_last);
  wire issue_wr = byte_done & (state_q == two_wire_pkg::D_RX) & addr_done & word_last;
  wire [7:0] tx_byte = two_wire_pkg::byte_sel(rword_q, byte_cnt_q);

  always_ff @(posedge link_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      scl_p_q <= 1'h0;
      sda_p_q <= 1'h0;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  always_ff @(posedge link_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q         <= two_wire_pkg::D_IDLE;
      bit_cnt_q       <= 4'h0;
      shift_q         <= 8'h00;
      rw_q            <= 1'h0;
      addr_cnt_q      <= 2'h0;
      byte_cnt_q      <= 2'h0;
      addr_q          <= 24'h000000;
      wdata_q         <= 32'h00000000;
      link.sda_dev_oe <= 1'h0;
    end else if (start_seen) begin
      // Also the path out of a bus reset: any START restarts address reception
      state_q         <= two_wire_pkg::D_ADDR;
      bit_cnt_q       <= 4'h0;
      link.sda_dev_oe <= 1'h0;
    end else if (stop_seen) begin
      state_q         <= two_wire_pkg::D_IDLE;
      link.sda_dev_oe <= 1'h0;
    end else begin
      if (scl_rise & in_count) begin
        bit_cnt_q <= bit_cnt_q + 4'h1;
      end
      if (scl_rise & in_shift) begin
        shift_q <= {shift_q[6:0], sda_s};
      end
      if (issue_rd | issue_wr) begin
        addr_q[15:0] <= addr_q[15:0] + 16'h0001;
      end
      unique case (state_q)
        two_wire_pkg::D_IDLE: begin
        end
        two_wire_pkg::D_ADDR: begin
          if (byte_done) begin
            if (addr_match) begin
              rw_q            <= shift_q[0];
              byte_cnt_q      <= 2'h0;
              link.sda_dev_oe <= 1'h1;
              state_q         <= two_wire_pkg::D_ACK_TX;
              if (shift_q[0] == `DIR_WRITE) begin
                addr_cnt_q <= 2'h0;
              end
            end else begin
              state_q <= two_wire_pkg::D_IDLE;
            end
          end
        end
        two_wire_pkg::D_RX: begin
          if (byte_done) begin
            link.sda_dev_oe <= 1'h1;
            state_q         <= two_wire_pkg::D_ACK_TX;
            if (!addr_done) begin
              addr_q     <= {addr_q[15:0], shift_q};
              addr_cnt_q <= addr_cnt_q + 2'h1;
            end else begin
              wdata_q    <= {wdata_q[23:0], shift_q};
              byte_cnt_q <= byte_cnt_q + 2'h1;
            end
          end
        end
        two_wire_pkg::D_ACK_TX: begin
          if (scl_fall) begin
            bit_cnt_q <= 4'h0;
            if (rw_q) begin
              shift_q         <= tx_byte;
              link.sda_dev_oe <= !tx_byte[7];
              state_q         <= two_wire_pkg::D_TX;
            end else begin
              link.sda_dev_oe <= 1'h0;
              state_q         <= two_wire_pkg::D_RX;
            end
          end
        end
        two_wire_pkg::D_TX: begin
          if (byte_done) begin
            link.sda_dev_oe <= 1'h0;
            state_q         <= two_wire_pkg::D_ACK_RX;
          end else if (scl_fall) begin
            shift_q         <= {shift_q[6:0], 1'h0};
            link.sda_dev_oe <= !shift_q[6];
          end
        end
        two_wire_pkg::D_ACK_RX: begin
          if (scl_rise & sda_s) begin
            state_q <= two_wire_pkg::D_IDLE;
          end else if (master_ack) begin
            byte_cnt_q <= byte_cnt_q + 2'h1;
          end else if (scl_fall) begin
            bit_cnt_q       <= 4'h0;
            shift_q         <= tx_byte;
            link.sda_dev_oe <= !tx_byte[7];
            state_q         <= two_wire_pkg::D_TX;
          end
        end
      endcase
    end
  end

  // Request bus stays stable until the next toggle, so the core side may sample it freely
  always_ff @(posedge link_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      req_tgl_q   <= 1'h0;
      req_we_q    <= 1'h0;
      req_addr_q  <= 24'h000000;
      req_wdata_q <= 32'h00000000;
    end else if (issue_rd | issue_wr) begin
      req_tgl_q   <= !req_tgl_q;
      req_we_q    <= issue_wr;
      req_addr_q  <= addr_q;
      req_wdata_q <= {wdata_q[23:0], shift_q};
    end
  end

  sync2 #(.WIDTH(1)) u_ack_sync (
    .clk_in   (link_clk_in),
    .rst_n_in (rst_n_in),
    .d_in     (ack_tgl_q),
    .q_out    (ack_s)
  );

  // Read data must arrive before the next SCL fall; at 400 kbps that leaves ample margin
  always_ff @(posedge link_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_p_q <= 1'h0;
      rword_q <= 32'h00000000;
    end else begin
      ack_p_q <= ack_s;
      if (ack_s ^ ack_p_q) begin
        rword_q <= rdata_q;
      end
    end
  end

  // ---------------- Core domain ----------------
  logic req_s;
  logic req_p_q;
  logic rd_pend_q;

  sync2 #(.WIDTH(1)) u_req_sync (
    .clk_in   (core_clk_in),
    .rst_n_in (rst_n_in),
    .d_in     (req_tgl_q),
    .q_out    (req_s)
  );

  wire req_new = req_s ^ req_p_q;

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      req_p_q       <= 1'h0;
      reg_rd_out    <= 1'h0;
      reg_wr_out    <= 1'h0;
      reg_addr_out  <= 24'h000000;
      reg_wdata_out <= 32'h00000000;
    end else begin
      req_p_q    <= req_s;
      reg_rd_out <= req_new & !req_we_q;
      reg_wr_out <= req_new & req_we_q;
      if (req_new) begin
        reg_addr_out  <= req_addr_q;
        reg_wdata_out <= req_wdata_q;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_pend_q <= 1'h0;
      rdata_q   <= 32'h00000000;
      ack_tgl_q <= 1'h0;
    end else begin
      rd_pend_q <= reg_rd_out;
      if (rd_pend_q) begin
        rdata_q   <= reg_hit_in ? reg_rdata_in : 32'h00000000;
        ack_tgl_q <= !ack_tgl_q;
      end
    end
  end

endmodule

// File: two_wire_regs.svh
`ifndef TWO_WIRE_REGS_SVH
`define TWO_WIRE_REGS_SVH

// Upper four bits of the 7-bit slave address
`define SLV_ADDR_FIXED 4'h8
// Number of register address bytes
`define ADDR_BYTES 2'h3
// Index of the last byte of a data word
`define LAST_DATA_BYTE 2'h3
// Bit counter value once eight bits have been clocked
`define ACK_SLOT 4'h8
// Direction bit values
`define DIR_WRITE 1'h0
`define DIR_READ 1'h1

// Shortest bus bit time at 400 kbps, and the core clock period
`define I2C_BIT_NS 2500
`define CORE_CLK_NS 10
// Quarter bit in core cycles, rounded up so the rate never exceeds the limit
`define I2C_QTR_CYC ((`I2C_BIT_NS + 4 * `CORE_CLK_NS - 1) / (4 * `CORE_CLK_NS))

`endif

// File: two_wire_pkg.sv
package two_wire_pkg;

  typedef enum logic [2:0] {D_IDLE, D_ADDR, D_RX, D_ACK_TX, D_TX, D_ACK_RX} dev_state_t;

  typedef enum logic [1:0] {OP_WRITE, OP_READ, OP_BUS_RESET} host_op_t;

  typedef enum logic [1:0] {SYM_START, SYM_STOP, SYM_TX, SYM_RX} sym_kind_t;

  typedef struct packed {
    sym_kind_t   kind;
    logic [7:0]  data;
    logic        last;
  } sym_t;

  // Byte 0 is bits [31:24], byte 3 is bits [7:0]
  function automatic logic [7:0] byte_sel(input logic [31:0] word, input logic [1:0] idx);
    logic [7:0] b;
    b = word[31:24];
    unique case (idx)
      2'h0: b = word[31:24];
      2'h1: b = word[23:16];
      2'h2: b = word[15:8];
      2'h3: b = word[7:0];
    endcase
    return b;
  endfunction

endpackage

// File: i2c_link_if.sv
`timescale 1ns/1ps
interface i2c_link_if;
  logic slave_scl_pin;
  logic sda_host_oe;
  logic sda_dev_oe;
  wire  slave_sda_pin;

  // Open drain with pull-up: low whenever either end enables its driver
  assign slave_sda_pin = !(sda_host_oe | sda_dev_oe);

  modport device (input slave_scl_pin, input slave_sda_pin, output sda_dev_oe);
  modport host   (output slave_scl_pin, output sda_host_oe, input slave_sda_pin);
endinterface

// File: sync2.sv
`timescale 1ns/1ps
module sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_q <= '0;
      q_out  <= '0;
    end else begin
      meta_q <= d_in;
      q_out  <= meta_q;
    end
  end
endmodule

// File: two_wire_bus_master.sv
`timescale 1ns/1ps
`include "two_wire_regs.svh"
module two_wire_bus_master #(
  parameter int QTR_CYC = `I2C_QTR_CYC
) (
  input  wire logic                   core_clk_in,
  input  wire logic                   rst_n_in,
  i2c_link_if.host                    link,
  input  wire logic                   cmd_valid_in,
  input  wire two_wire_pkg::host_op_t cmd_op_in,
  input  wire logic            [23:0] cmd_addr_in,
  input  wire logic            [31:0] cmd_wdata_in,
  input  wire logic             [2:0] target_port_addr_in,
  output logic                        cmd_ready_out,
  output logic                        done_out,
  output logic                        nack_out,
  output logic                 [31:0] rdata_out
);

  two_wire_pkg::host_op_t op_q;
  logic                   run_q;
  logic [23:0]            addr_q;
  logic [31:0]            wdata_q;
  logic [6:0]             dev_q;
  logic [15:0]            tick_q;
  logic [1:0]             qtr_q;
  logic [3:0]             slot_q;
  logic [3:0]             idx_q;
  logic [7:0]             sh_q;
  logic [31:0]            rbuf_q;
  logic                   sda_s;
  two_wire_pkg::sym_t     cur;

  // Transfer script: one symbol per index
  function automatic two_wire_pkg::sym_t sym_f(input two_wire_pkg::host_op_t op,
                                               input logic [3:0] idx);
    two_wire_pkg::sym_t s;
    s.kind = two_wire_pkg::SYM_STOP;
    s.data = 8'hFF;
    s.last = 1'h0;
    if (op == two_wire_pkg::OP_BUS_RESET) begin
      // START, nine clocks with SDA high, START, STOP
      if (idx == 4'h0 || idx == 4'h2) s.kind = two_wire_pkg::SYM_START;
      if (idx == 4'h1) s.kind = two_wire_pkg::SYM_TX;
    end else if (idx == 4'h0 || (op == two_wire_pkg::OP_READ && idx == 4'h5)) begin
      s.kind = two_wire_pkg::SYM_START;
    end else if (idx == 4'h1) begin
      s.kind = two_wire_pkg::SYM_TX;
      s.data = {dev_q, `DIR_WRITE};
    end else if (idx <= 4'h4) begin
      s.kind = two_wire_pkg::SYM_TX;
      s.data = two_wire_pkg::byte_sel({8'h00, addr_q}, 2'(idx - 4'h1));
    end else if (op == two_wire_pkg::OP_WRITE && idx <= 4'h8) begin
      s.kind = two_wire_pkg::SYM_TX;
      s.data = two_wire_pkg::byte_sel(wdata_q, 2'(idx - 4'h5));
    end else if (op == two_wire_pkg::OP_READ && idx == 4'h6) begin
      s.kind = two_wire_pkg::SYM_TX;
      s.data = {dev_q, `DIR_READ};
    end else if (op == two_wire_pkg::OP_READ && idx <= 4'hA) begin
      s.kind = two_wire_pkg::SYM_RX;
      s.last = idx == 4'hA;
    end
    return s;
  endfunction

  sync2 #(.WIDTH(1)) u_sda_sync (
    .clk_in   (core_clk_in),
    .rst_n_in (rst_n_in),
    .d_in     (link.slave_sda_pin),
    .q_out    (sda_s)
  );

  assign cur = sym_f(op_q, idx_q);

  wire       tick     = run_q & (tick_q == 16'(QTR_CYC - 1));
  wire       ack_slot = slot_q == `ACK_SLOT;
  wire [2:0] bit_i    = 3'(4'h7 - slot_q);
  wire       is_start = cur.kind == two_wire_pkg::SYM_START;
  wire       is_stop  = cur.kind == two_wire_pkg::SYM_STOP;
  wire       is_tx    = cur.kind == two_wire_pkg::SYM_TX;
  wire       is_rx    = cur.kind == two_wire_pkg::SYM_RX;
  // SDA driver for the low phase of each slot
  wire       drive_lo = is_stop
                      | (is_tx & !ack_slot & !cur.data[bit_i])
                      | (is_rx & ack_slot & !cur.last);

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tick_q <= 16'h0000;
    end else begin
      tick_q <= (tick | !run_q) ? 16'h0000 : tick_q + 16'h0001;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      op_q          <= two_wire_pkg::OP_WRITE;
      run_q         <= 1'h0;
      addr_q        <= 24'h000000;
      wdata_q       <= 32'h00000000;
      dev_q         <= 7'h00;
      qtr_q         <= 2'h0;
      slot_q        <= 4'h0;
      idx_q         <= 4'h0;
      sh_q          <= 8'h00;
      rbuf_q        <= 32'h00000000;
      cmd_ready_out <= 1'h1;
      done_out      <= 1'h0;
      nack_out      <= 1'h0;
      rdata_out     <= 32'h00000000;
      link.slave_scl_pin <= 1'h1;
      link.sda_host_oe   <= 1'h0;
    end else begin
      done_out <= 1'h0;
      if (!run_q) begin
        if (cmd_valid_in) begin
          op_q          <= cmd_op_in;
          addr_q        <= cmd_addr_in;
          wdata_q       <= cmd_wdata_in;
          dev_q         <= {`SLV_ADDR_FIXED, target_port_addr_in};
          run_q         <= 1'h1;
          qtr_q         <= 2'h0;
          slot_q        <= 4'h0;
          idx_q         <= 4'h0;
          cmd_ready_out <= 1'h0;
          nack_out      <= 1'h0;
        end
      end else if (tick) begin
        qtr_q <= qtr_q + 2'h1;
        unique case (qtr_q)
          2'h0: begin
            // SDA only moves while SCL is low; an opening START keeps SCL high, so no stray pulse
            link.slave_scl_pin <= is_start & (idx_q == 4'h0);
            link.sda_host_oe   <= drive_lo;
          end
          2'h1: begin
            link.slave_scl_pin <= 1'h1;
          end
          2'h2: begin
            if (is_start) link.sda_host_oe <= 1'h1;
            if (is_stop) link.sda_host_oe <= 1'h0;
            if (is_rx & !ack_slot) sh_q <= {sh_q[6:0], sda_s};
            if (is_tx & ack_slot & sda_s & (op_q != two_wire_pkg::OP_BUS_RESET)) begin
              nack_out <= 1'h1;
            end
          end
          2'h3: begin
            if (is_stop) begin
              run_q         <= 1'h0;
              cmd_ready_out <= 1'h1;
              done_out      <= 1'h1;
              rdata_out     <= rbuf_q;
            end else begin
              link.slave_scl_pin <= 1'h0;
              if ((is_tx | is_rx) & !ack_slot) begin
                slot_q <= slot_q + 4'h1;
              end else begin
                slot_q <= 4'h0;
                idx_q  <= idx_q + 4'h1;
                if (is_rx) rbuf_q <= {rbuf_q[23:0], sh_q};
              end
            end
          end
        endcase
      end
    end
  end

endmodule

// File: two_wire_link_sva.sv
`timescale 1ns/1ps
module two_wire_link_sva #(
  parameter int QTR_CYC = 63
) (
  input  wire logic core_clk_in,
  input  wire logic rst_n_in,
  input  wire logic slave_scl_pin,
  input  wire logic sda_host_oe,
  input  wire logic sda_dev_oe,
  input  wire logic slave_sda_pin
);
  logic [15:0] run_q;
  logic [7:0]  pulse_q;
  logic        scl_q;
  logic        sda_q;
  logic        in_frame_q;

  wire         start_w = sda_q & !slave_sda_pin & slave_scl_pin & scl_q;
  wire         stop_w  = !sda_q & slave_sda_pin & slave_scl_pin & scl_q;
  wire         fall_w  = scl_q & !slave_scl_pin;
  // Saturate so a long idle high never wraps into a short-looking run
  wire  [15:0] run_d   = (slave_scl_pin != scl_q) ? 16'h1 :
                         (run_q == 16'hFFFF) ? run_q : run_q + 16'h1;
  wire  [7:0]  pulse_d = start_w ? 8'h0 : (fall_w && in_frame_q) ? pulse_q + 8'h1 : pulse_q;
  wire         frame_d = start_w | (in_frame_q & !stop_w);

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      run_q      <= 16'h0;
      pulse_q    <= 8'h0;
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
      in_frame_q <= 1'b0;
    end else begin
      run_q      <= run_d;
      pulse_q    <= pulse_d;
      scl_q      <= slave_scl_pin;
      sda_q      <= slave_sda_pin;
      in_frame_q <= frame_d;
    end
  end

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  a_scl_high_min: assert property ($fell(slave_scl_pin) && in_frame_q |-> run_q >= 16'(2 * QTR_CYC))
    else $error("clock high phase shorter than two quarters");
  a_scl_low_len: assert property ($rose(slave_scl_pin) |-> run_q == 16'(2 * QTR_CYC))
    else $error("clock low phase not two quarters");
  a_dev_sda_still: assert property (slave_scl_pin && scl_q |-> $stable(sda_dev_oe))
    else $error("device moved data while clock high");
  a_start_by_host: assert property (start_w |-> sda_host_oe && !sda_dev_oe)
    else $error("start not made by host alone");
  a_stop_released: assert property (stop_w |-> !sda_host_oe && !sda_dev_oe)
    else $error("stop with a driver still on");
  a_scl_idle_high: assert property (!in_frame_q |-> slave_scl_pin)
    else $error("clock low outside a frame");
  a_dev_idle_quiet: assert property (!in_frame_q |-> !sda_dev_oe)
    else $error("device drives data outside a frame");
  // The start symbol's own clock fall counts one, so the address byte ends at nine
  a_no_drive_addr: assert property ($rose(sda_dev_oe) |-> pulse_q >= 8'h9)
    else $error("device drove data during the address byte");
endmodule

// File: tb.sv
`timescale 1ns/1ps
module tb;
  localparam int QTR = 12;
  logic                   core_clk_in;
  logic                   link_clk_in;
  logic                   rst_n_in;
  logic                   cmd_valid;
  logic                   cmd_ready;
  logic                   done;
  logic                   nack;
  logic                   reg_hit = 1'b0;
  logic                   reg_rd;
  logic                   reg_wr;
  two_wire_pkg::host_op_t cmd_op;
  logic [2:0]             target_pa;
  logic [2:0]             port_pa;
  logic [23:0]            cmd_addr;
  logic [23:0]            reg_addr;
  logic [23:0]            wr_addr;
  logic [23:0]            rd_addr;
  logic [31:0]            cmd_wdata;
  logic [31:0]            rdata;
  logic [31:0]            reg_rdata = 32'h00000000;
  logic [31:0]            reg_wdata;
  logic [31:0]            wr_data;
  logic [31:0]            regs_m [logic [23:0]];
  int                     err_total;
  int                     check_count;
  int                     wr_cnt = 0;

  i2c_link_if u_i2c_link_if ();

  two_wire_register_slave u_two_wire_register_slave (
    .core_clk_in(core_clk_in), .link_clk_in(link_clk_in), .rst_n_in(rst_n_in),
    .link(u_i2c_link_if.device), .port_addr_4_in(port_pa[2]), .port_addr_3_in(port_pa[1]),
    .port_addr_2_in(port_pa[0]), .reg_rdata_in(reg_rdata), .reg_hit_in(reg_hit),
    .reg_rd_out(reg_rd), .reg_wr_out(reg_wr), .reg_addr_out(reg_addr), .reg_wdata_out(reg_wdata));

  two_wire_bus_master #(.QTR_CYC(QTR)) u_two_wire_bus_master (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .link(u_i2c_link_if.host),
    .cmd_valid_in(cmd_valid), .cmd_op_in(cmd_op), .cmd_addr_in(cmd_addr),
    .cmd_wdata_in(cmd_wdata), .target_port_addr_in(target_pa), .cmd_ready_out(cmd_ready),
    .done_out(done), .nack_out(nack), .rdata_out(rdata));

  two_wire_link_sva #(.QTR_CYC(QTR)) u_two_wire_link_sva (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
    .slave_scl_pin(u_i2c_link_if.slave_scl_pin), .sda_host_oe(u_i2c_link_if.sda_host_oe),
    .sda_dev_oe(u_i2c_link_if.sda_dev_oe), .slave_sda_pin(u_i2c_link_if.slave_sda_pin));

  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end

  // Odd offset keeps the link clock out of phase with the core clock
  initial begin
    link_clk_in = 1'b0;
    #7;
    forever #15 link_clk_in = ~link_clk_in;
  end

  // Register file behind the device; garbage on a miss proves it is masked
  always @(posedge core_clk_in) begin
    if (reg_wr === 1'b1) begin
      regs_m[reg_addr] = reg_wdata;
      wr_addr = reg_addr;
      wr_data = reg_wdata;
      wr_cnt++;
    end
    if (reg_rd === 1'b1) begin
      rd_addr = reg_addr;
      reg_hit <= (regs_m.exists(reg_addr) != 0);
      reg_rdata <= (regs_m.exists(reg_addr) != 0) ? regs_m[reg_addr] : 32'hDEAD_BEEF;
    end
  end

  task automatic fail(input string msg);
    $display("ERROR at %0t: %s", $time, msg);
    err_total++;
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) fail($sformatf("%s got %h expected %h", what, got, exp));
  endtask

  task automatic check_bit(input logic got, input logic exp, input string what);
    check_count++;
    if (got !== exp) fail($sformatf("%s got %b expected %b", what, got, exp));
  endtask

  // Host is idle between calls, so the command is taken at the second edge
  task automatic run_cmd(input two_wire_pkg::host_op_t op, input logic [23:0] a,
                         input logic [31:0] d, input logic [2:0] pa);
    int n;
    n = 0;
    @(posedge core_clk_in);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_addr <= a;
    cmd_wdata <= d;
    target_pa <= pa;
    @(posedge core_clk_in);
    cmd_valid <= 1'b0;
    while (done !== 1'b1 && n < 20000) begin
      @(negedge core_clk_in);
      n++;
    end
    if (n >= 20000) fail("command never completed");
    check_bit(cmd_ready, 1'b1, "host ready at done");
  endtask

  task automatic end_test(input string name);
    $display("test %s finished, mismatches so far %0d", name, err_total);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    logic [2:0]  p;
    logic [23:0] a;
    logic [31:0] d;
    int          n;
    rst_n_in = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = two_wire_pkg::OP_WRITE;
    cmd_addr = 24'h0;
    cmd_wdata = 32'h0;
    target_pa = 3'h0;
    port_pa = 3'h5;
    err_total = 0;
    check_count = 0;
    repeat (16) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      p = (i == 0) ? 3'h5 : 3'h2;
      a = 24'h3E0100 + 24'(i);
      d = (i == 0) ? 32'h81C3_5A0F : 32'h0F5A_C381;
      @(posedge core_clk_in);
      port_pa <= p;
      repeat (20) @(posedge core_clk_in);
      run_cmd(two_wire_pkg::OP_WRITE, a, d, p);
      check_bit(nack, 1'b0, "write ack");
      check_word({8'h0, wr_addr}, {8'h0, a}, "write address");
      check_word(wr_data, d, "write data");
      run_cmd(two_wire_pkg::OP_READ, a, 32'h0, p);
      check_bit(nack, 1'b0, "read ack");
      check_word({8'h0, rd_addr}, {8'h0, a}, "read address");
      check_word(rdata, d, "read data");
      n = wr_cnt;
      run_cmd(two_wire_pkg::OP_WRITE, a, ~d, p ^ 3'h4);
      check_bit(nack, 1'b1, "foreign address ack");
      check_word(32'(wr_cnt), 32'(n), "foreign write count");
      end_test("address and transfer");
    end
    run_cmd(two_wire_pkg::OP_READ, 24'h7F1234, 32'h0, 3'h2);
    check_bit(nack, 1'b0, "invalid read ack");
    check_word(rdata, 32'h0, "invalid read data");
    end_test("invalid register");
    run_cmd(two_wire_pkg::OP_BUS_RESET, 24'h0, 32'h0, 3'h2);
    check_bit(nack, 1'b0, "bus reset flag");
    run_cmd(two_wire_pkg::OP_READ, 24'h3E0101, 32'h0, 3'h2);
    check_word(rdata, 32'h0F5A_C381, "read after bus reset");
    end_test("bus reset");
    close_out();
  end

  // Eight commands of about four thousand cycles each plus one short bus reset, with ample margin
  initial begin
    repeat (80000) @(posedge core_clk_in);
    fail("watchdog expired");
    close_out();
  end
endmodule
